// *** fcs_pkg.sv ***
// Package with constants and carrier types of the flame controller supervision block.
package fcs_pkg;
  // Timing and rate threshold step.
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int WINDOW_MS = 1000;
  localparam logic [3:0] WINDOW_TICKS = 4'(WINDOW_MS / TICK_MS);
  localparam int POWERUP_MS = 1000;
  localparam logic [3:0] POWERUP_TICKS = 4'(POWERUP_MS / TICK_MS);
  localparam int DELAY_MIN_MS = 200;
  localparam int DELAY_MAX_MS = 12000;
  localparam int DELAY_DEF_MS = 5000;
  localparam logic [6:0] DELAY_MIN_TICKS = 7'((DELAY_MIN_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [6:0] DELAY_MAX_TICKS = 7'(DELAY_MAX_MS / TICK_MS);
  localparam logic [6:0] DELAY_DEF_TICKS = 7'(DELAY_DEF_MS / TICK_MS);
  localparam logic [7:0] THR_STEP_CPS = 8'h19;
  // Register offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DELAY = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_RATE = 8'h14;
  // Control field positions and reset values.
  localparam int CTRL_THR_LSB = 0;
  localparam int CTRL_CNT_LSB = 2;
  localparam int CTRL_LOOP_LSB = 6;
  localparam logic [1:0] THR_SEL_RST = 2'h0;
  localparam logic [3:0] DET_COUNT_RST = 4'h8;
  localparam logic [3:0] DET_COUNT_MAX = 4'h8;
  localparam logic [2:0] LOOPS_RST = 3'h1;
  localparam logic [2:0] LOOPS_MAX = 3'h4;
  // Interrupt bits.
  localparam int IRQ_W = 3;
  localparam int IRQ_INSTANT = 0;
  localparam int IRQ_TIMED = 1;
  localparam int IRQ_FAULT = 2;
  // Display codes.
  localparam logic [3:0] CODE_DET = 4'h2;
  localparam logic [3:0] CODE_WIRE = 4'h3;
  localparam logic [3:0] CODE_BYPASS = 4'h8;
  typedef struct packed {
    logic [1:0] thr_sel;
    logic [3:0] det_count;
    logic [2:0] eol_loops;
  } fcs_cfg_t;
  typedef struct packed {
    logic enable;
    logic [3:0] left;
    logic [3:0] right;
  } fcs_disp_t;
endpackage

// *** fcs_supervisor.sv ***
// Flame controller supervision: rate detection, timed output, self-test scan and fault report.
`timescale 1ns/1ps
module fcs_supervisor #(
  parameter int N_DET = 8,
  parameter int TICK_CYCLES = fcs_pkg::TICK_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [N_DET-1:0] uv_pulse,
  input wire logic [N_DET-1:0] det_present,
  input wire logic [N_DET-1:0] optic_echo,
  input wire logic [2:0] eol_sense,
  input wire logic remote_reset_closed,
  input wire logic bypass_switch,
  input wire logic self_test_button,
  input wire logic select_button,
  output logic instant_out,
  output logic instant_indicator,
  output logic timed_out,
  output logic delayed_indicator,
  output logic fault_relay,
  output logic fault_indicator,
  output fcs_pkg::fcs_disp_t disp,
  output logic irq
);
  localparam int TW = $clog2(TICK_CYCLES);

  // Parameters the logic cannot serve are refused.
  if (N_DET < 1 || N_DET > 8 || TICK_CYCLES < 2) begin : g_chk
    $error("fcs_supervisor: unsupported parameter value");
  end

  // Counts the pulses arriving in one cycle.
  function automatic logic [3:0] pop(input logic [N_DET-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < N_DET; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // A detector count is usable from 1 to 8.
  function automatic logic cnt_ok(input logic [3:0] c);
    return c != 4'h0 && c <= fcs_pkg::DET_COUNT_MAX;
  endfunction

  fcs_pkg::fcs_cfg_t cfg_q;
  logic [6:0] delay_q;
  logic [fcs_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, ev;
  logic [TW-1:0] tick_cnt_q;
  logic tick;
  logic [3:0] win_q, pu_q;
  logic [7:0] rate_q, last_rate_q;
  logic rate_ok_q, instant_q, timed_q, pu_active;
  logic [6:0] dly_cnt_q;
  logic [2:0] scan_q, sel_q;
  logic sel_btn_q;
  logic [N_DET-1:0] opt_fail_q, in_cfg, missing, det_fault;
  logic wire_fault, live_fault, live_q, latch_q, latch_d, test_ok, instant_d;
  logic [3:0] fault_num;
  logic [3:0] pc;
  logic [7:0] thr;

  // Base tick of 100 ms from the system clock.
  // A shorter tick parameter speeds up simulation without changing any ratio.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = tick_cnt_q == TW'(TICK_CYCLES - 1);

  // Register writes; illegal counts and loop settings are ignored, delay is clamped.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q.thr_sel <= fcs_pkg::THR_SEL_RST;
      cfg_q.det_count <= fcs_pkg::DET_COUNT_RST;
      cfg_q.eol_loops <= fcs_pkg::LOOPS_RST;
      delay_q <= fcs_pkg::DELAY_DEF_TICKS;
      irq_mask_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == fcs_pkg::REG_CTRL) begin
        cfg_q.thr_sel <= reg_wdata[fcs_pkg::CTRL_THR_LSB +: 2];
        if (cnt_ok(reg_wdata[fcs_pkg::CTRL_CNT_LSB +: 4])) begin
          cfg_q.det_count <= reg_wdata[fcs_pkg::CTRL_CNT_LSB +: 4];
        end
        if (reg_wdata[fcs_pkg::CTRL_LOOP_LSB +: 3] != 3'h0 &&
            reg_wdata[fcs_pkg::CTRL_LOOP_LSB +: 3] <= fcs_pkg::LOOPS_MAX) begin
          cfg_q.eol_loops <= reg_wdata[fcs_pkg::CTRL_LOOP_LSB +: 3];
        end
      end
      if (reg_addr == fcs_pkg::REG_DELAY) begin
        if (reg_wdata[31:0] < 32'(fcs_pkg::DELAY_MIN_TICKS)) begin
          delay_q <= fcs_pkg::DELAY_MIN_TICKS;
        end else if (reg_wdata[31:0] > 32'(fcs_pkg::DELAY_MAX_TICKS)) begin
          delay_q <= fcs_pkg::DELAY_MAX_TICKS;
        end else begin
          delay_q <= reg_wdata[6:0];
        end
      end
      if (reg_addr == fcs_pkg::REG_IRQ_MASK) begin
        irq_mask_q <= reg_wdata[fcs_pkg::IRQ_W-1:0];
      end
    end
  end

  // Pulse rate over a one second window, compared with the selected threshold.
  assign pc = pop(uv_pulse);
  assign thr = 8'(({6'h0, cfg_q.thr_sel} + 8'h01) * fcs_pkg::THR_STEP_CPS);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_q <= 4'h0;
      rate_q <= 8'h00;
      last_rate_q <= 8'h00;
      rate_ok_q <= 1'b0;
    end else if (tick && win_q == fcs_pkg::WINDOW_TICKS - 4'h1) begin
      win_q <= 4'h0;
      rate_q <= {4'h0, pc};
      last_rate_q <= rate_q;
      rate_ok_q <= rate_q >= thr;
    end else begin
      if (tick) begin
        win_q <= win_q + 4'h1;
      end
      rate_q <= (rate_q > 8'hff - {4'h0, pc}) ? 8'hff : rate_q + {4'h0, pc};
    end
  end

  // Manual test passes when the selected detector is present and returns its echo.
  assign test_ok = self_test_button && det_present[sel_q] && optic_echo[sel_q];
  assign instant_d = rate_ok_q || test_ok;

  // Instant output and the delay count, restarted on any loss of detection.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      instant_q <= 1'b0;
      timed_q <= 1'b0;
      dly_cnt_q <= 7'h00;
    end else begin
      instant_q <= instant_d;
      if (!instant_d) begin
        dly_cnt_q <= 7'h00;
        timed_q <= 1'b0;
      end else begin
        // The first tick after detection starts may come at once, so it is not counted:
        // timed rises after the full delay and at most one tick later, never earlier.
        if (tick && dly_cnt_q <= delay_q) begin
          dly_cnt_q <= dly_cnt_q + 7'h01;
        end
        timed_q <= dly_cnt_q > delay_q;
      end
    end
  end

  // Automatic optical scan of the configured detectors only.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_q <= 3'h0;
      opt_fail_q <= '0;
    end else begin
      opt_fail_q <= opt_fail_q & in_cfg;
      if (tick) begin
        opt_fail_q[scan_q] <= ~optic_echo[scan_q] & in_cfg[scan_q];
      end
      // A smaller count written mid-scan pulls the pointer back in the next cycle; a tick falling in that cycle
      // still lands outside the configured set, where in_cfg keeps the optical fail clear.
      if (tick || {1'b0, scan_q} >= cfg_q.det_count) begin
        if ({1'b0, scan_q} + 4'h1 >= cfg_q.det_count) begin
          scan_q <= 3'h0;
        end else begin
          scan_q <= scan_q + 3'h1;
        end
      end
    end
  end

  // Detectors inside the configured count, and those missing among them.
  for (genvar i = 0; i < N_DET; i++) begin : g_det
    assign in_cfg[i] = 4'(i) < cfg_q.det_count;
    assign missing[i] = in_cfg[i] && !det_present[i];
  end
  assign det_fault = missing | opt_fail_q;
  // The loop current is only a count here; any mismatch, open or short, is a fault.
  assign wire_fault = eol_sense != cfg_q.eol_loops;
  assign live_fault = (|det_fault) || wire_fault;

  // Lowest faulty detector number, counted from one.
  always_comb begin
    fault_num = 4'h0;
    for (int i = N_DET - 1; i >= 0; i--) begin
      if (det_fault[i]) begin
        fault_num = 4'(i + 1);
      end
    end
  end

  // Selection of the detector for manual test, stepped by the select button.
  // Stepping wraps at the configured count; a count lowered later leaves an unused head selected until the next step.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= 3'h0;
      sel_btn_q <= 1'b0;
    end else begin
      sel_btn_q <= select_button;
      if (select_button && !sel_btn_q) begin
        sel_q <= ({1'b0, sel_q} + 4'h1 >= cfg_q.det_count) ? 3'h0 : sel_q + 3'h1;
      end
    end
  end

  // Power-up flash time of the fault indicator.
  // The flash also tells the operator that the supervisor came out of reset.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_q <= 4'h0;
    end else if (tick && pu_active) begin
      pu_q <= pu_q + 4'h1;
    end
  end
  assign pu_active = pu_q != fcs_pkg::POWERUP_TICKS;

  // A held reset closure makes the latch transparent to the live fault.
  assign latch_d = live_fault || (latch_q && !remote_reset_closed);

  // Fault latch, relay, indicator and display.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= 1'b0;
      live_q <= 1'b0;
      fault_relay <= 1'b0;
      fault_indicator <= 1'b1;
      disp <= '0;
    end else begin
      latch_q <= latch_d;
      live_q <= live_fault;
      fault_relay <= !live_fault;
      fault_indicator <= latch_d || pu_active || bypass_switch;
      if (bypass_switch) begin
        disp <= '{1'b1, {1'b0, sel_q} + 4'h1, fcs_pkg::CODE_BYPASS};
      end else if (|det_fault) begin
        disp <= '{1'b1, fault_num, fcs_pkg::CODE_DET};
      end else if (wire_fault) begin
        disp <= '{1'b1, 4'h0, fcs_pkg::CODE_WIRE};
      end else if (!latch_d) begin
        // A latched fault with no live cause keeps its last code on show until reset.
        disp <= '0;
      end
    end
  end

  assign instant_out = instant_q;
  assign instant_indicator = instant_q;
  assign timed_out = timed_q;
  assign delayed_indicator = timed_q;

  // Sticky interrupt status; a new event wins over a write-one clear.
  assign ev[fcs_pkg::IRQ_INSTANT] = instant_d && !instant_q;
  assign ev[fcs_pkg::IRQ_TIMED] = !timed_q && instant_d && dly_cnt_q > delay_q;
  assign ev[fcs_pkg::IRQ_FAULT] = live_fault && !live_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == fcs_pkg::REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~reg_wdata[fcs_pkg::IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read data, valid only in the cycle after the read strobe.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0;
    end else begin
      unique case (reg_addr)
        fcs_pkg::REG_CTRL: reg_rdata <= 32'({cfg_q.eol_loops, cfg_q.det_count, cfg_q.thr_sel});
        fcs_pkg::REG_DELAY: reg_rdata <= 32'(delay_q);
        fcs_pkg::REG_STATUS: reg_rdata <= 32'({wire_fault, |det_fault, latch_q, bypass_switch,
                                                 live_fault, timed_q, instant_q});
        fcs_pkg::REG_IRQ_STAT: reg_rdata <= 32'(irq_stat_q);
        fcs_pkg::REG_IRQ_MASK: reg_rdata <= 32'(irq_mask_q);
        fcs_pkg::REG_RATE: reg_rdata <= 32'(last_rate_q);
        default: reg_rdata <= 32'h0;
      endcase
    end
  end

  // Checks on the design's own state and outputs, all in the core clock domain.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_test_press;
    test_ok ##1 test_ok;
  endsequence

  latch_hold_a: assert property (latch_q && !live_fault && !remote_reset_closed |=> latch_q)
    else $error("fault latch released without reset closure");
  follow_a: assert property (remote_reset_closed && !live_fault && !pu_active && !bypass_switch
    |=> !fault_indicator)
    else $error("fault indicator stuck with reset closed");
  powerup_a: assert property (pu_active |=> fault_indicator)
    else $error("no power-up flash");
  relay_drop_a: assert property (live_fault |=> !fault_relay ##0 $past(live_fault))
    else $error("fault relay energized during fault");
  det_count_a: assert property (cnt_ok(cfg_q.det_count))
    else $error("illegal detector count");
  missing_code_a: assert property (!bypass_switch && (|missing)
    |=> disp.enable && disp.right == fcs_pkg::CODE_DET && disp.left != 4'h0)
    else $error("missing detector not shown");
  scan_range_a: assert property ({1'b0, scan_q} < cfg_q.det_count || $changed(cfg_q))
    else $error("scan beyond configured detectors");
  delay_range_a: assert property (delay_q >= fcs_pkg::DELAY_MIN_TICKS
    && delay_q <= fcs_pkg::DELAY_MAX_TICKS)
    else $error("delay out of range");
  bypass_disp_a: assert property (bypass_switch |=> disp.enable && fault_indicator
    && disp.right == fcs_pkg::CODE_BYPASS && disp.left == {1'b0, $past(sel_q)} + 4'h1)
    else $error("bypass display wrong");
  test_instant_a: assert property (s_test_press |-> instant_q)
    else $error("manual test did not assert instant output");
  timed_needs_a: assert property (timed_q |-> instant_q && dly_cnt_q > delay_q)
    else $error("timed output without full delay");
  loss_clear_a: assert property ($fell(instant_q) |-> !timed_q && dly_cnt_q == 7'h00)
    else $error("loss of detection did not clear timer");
  wire_fault_a: assert property (eol_sense != cfg_q.eol_loops |=> !fault_relay)
    else $error("loop mismatch not flagged");
endmodule

// *** fcs_det_model.sv ***
// Behavioural model of the UV detector heads on the controller's loops.
`timescale 1ns/1ps
module fcs_det_model #(
  parameter int N = 8
) (
  input wire logic core_clk,
  input wire logic [N-1:0] present_mask,
  input wire logic [N-1:0] echo_mask,
  input wire logic [31:0] pulse_period,
  input wire logic [2:0] pulse_det,
  output logic [N-1:0] uv_pulse,
  output logic [N-1:0] det_present,
  output logic [N-1:0] optic_echo
);
  logic [31:0] cnt_q = 32'h0;
  logic flip_q = 1'b0;
  // A lit head sends one count every pulse_period cycles; zero means dark.
  always @(posedge core_clk) begin
    flip_q <= ~flip_q;
    uv_pulse <= '0;
    if (pulse_period == 32'h0 || cnt_q >= pulse_period - 32'h1) cnt_q <= 32'h0;
    else cnt_q <= cnt_q + 32'h1;
    if (pulse_period != 32'h0 && cnt_q == 32'h0 && present_mask[pulse_det]) begin
      uv_pulse[pulse_det] <= 1'b1;
    end
  end
  // An absent head leaves its echo line floating, shown as a level toggling each cycle.
  assign det_present = present_mask;
  assign optic_echo = (echo_mask & present_mask) | ({N{flip_q}} & ~present_mask);
endmodule

// *** tb_fcs_supervisor.sv ***
// Self-checking testbench of the flame controller supervision block.
`timescale 1ns/1ps
module tb_fcs_supervisor;
  logic core_clk, reset_n, reg_wr, reg_rd, remote_reset_closed, bypass_switch;
  logic self_test_button, select_button, instant_out, instant_indicator, timed_out;
  logic delayed_indicator, fault_relay, fault_indicator, irq;
  logic [7:0] reg_addr, uv_pulse, det_present, optic_echo, present_mask, echo_mask;
  logic [31:0] reg_wdata, reg_rdata, pulse_period;
  logic [2:0] eol_sense, pulse_det;
  fcs_pkg::fcs_disp_t disp;
  int fails = 0;
  int compares = 0;
  int seed = 32'h89c8;
  int t;
  int per[4] = '{2, 4, 5, 10};
  fcs_supervisor #(.N_DET(8), .TICK_CYCLES(10)) fcs_supervisor_i (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uv_pulse(uv_pulse), .det_present(det_present),
    .optic_echo(optic_echo), .eol_sense(eol_sense), .remote_reset_closed(remote_reset_closed),
    .bypass_switch(bypass_switch), .self_test_button(self_test_button),
    .select_button(select_button), .instant_out(instant_out),
    .instant_indicator(instant_indicator), .timed_out(timed_out),
    .delayed_indicator(delayed_indicator), .fault_relay(fault_relay),
    .fault_indicator(fault_indicator), .disp(disp), .irq(irq));
  fcs_det_model #(.N(8)) fcs_det_model_i (.core_clk(core_clk), .present_mask(present_mask),
    .echo_mask(echo_mask), .pulse_period(pulse_period), .pulse_det(pulse_det),
    .uv_pulse(uv_pulse), .det_present(det_present), .optic_echo(optic_echo));
  // Clock of 100 ns period.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    cmp(reg_rdata, e, m);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // Holds the test button and counts cycles until the timed output rises.
  task automatic press(output int n);
    @(posedge core_clk);
    self_test_button <= 1'b1;
    n = 0;
    while (timed_out !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic btn_off;
    @(posedge core_clk);
    self_test_button <= 1'b0;
    cyc(2);
  endtask
  // Watchdog against a hang.
  initial begin
    #(100 * 30000);
    fails++;
    report_and_stop();
  end
  initial begin
    {reset_n, reg_wr, reg_rd, bypass_switch, self_test_button, select_button} = '0;
    {reg_addr, reg_wdata, pulse_period, pulse_det} = '0;
    {present_mask, echo_mask, eol_sense, remote_reset_closed} = {8'hff, 8'hff, 3'h1, 1'b1};
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    cyc(3);
    cmp(fault_indicator, 1'b1, "power-up lamp");
    cmp(fault_relay, 1'b1, "relay energized");
    rdchk(fcs_pkg::REG_CTRL, 32'h60, "ctrl reset");
    rdchk(fcs_pkg::REG_DELAY, 32'h32, "delay reset");
    rdchk(8'h40, 32'h0, "unmapped read");
    rdchk(fcs_pkg::REG_IRQ_MASK, 32'h0, "mask reset");
    cyc(150);
    cmp(fault_indicator, 1'b0, "lamp clears");
    wr(fcs_pkg::REG_DELAY, 32'h1);
    rdchk(fcs_pkg::REG_DELAY, 32'h2, "delay floor");
    wr(fcs_pkg::REG_DELAY, 32'hc8);
    rdchk(fcs_pkg::REG_DELAY, 32'h78, "delay ceiling");
    // Each threshold against a random pulse rate from a random head.
    for (int s = 0; s < 4; s++) begin
      t = per[$random(seed) & 3];
      wr(fcs_pkg::REG_CTRL, 32'h60 | 32'(s));
      @(posedge core_clk);
      pulse_period <= 32'(t);
      pulse_det <= 3'($random(seed));
      cyc(250);
      cmp(instant_out, 32'((100 / t) >= 25 * (s + 1)), "instant vs threshold");
      cmp(instant_indicator, instant_out, "instant lamp");
      rdchk(fcs_pkg::REG_RATE, 32'(100 / t), "rate count");
    end
    wr(fcs_pkg::REG_CTRL, 32'h60);
    @(posedge core_clk);
    pulse_period <= 32'h0;
    cyc(250);
    cmp({instant_out, timed_out}, 2'b00, "dark clears outputs");
    wr(fcs_pkg::REG_DELAY, 32'h3);
    wr(fcs_pkg::REG_IRQ_STAT, 32'h7);
    wr(fcs_pkg::REG_IRQ_MASK, 32'h1);
    cyc(3);
    cmp(irq, 1'b0, "irq idle");
    press(t);
    cmp(32'(t >= 30 && t <= 50), 32'h1, "timed delay");
    cmp({instant_out, delayed_indicator, irq}, 3'b111, "test success");
    rdchk(fcs_pkg::REG_STATUS, 32'h3, "status while held");
    btn_off();
    cmp({instant_out, timed_out, delayed_indicator}, 3'b000, "release clears");
    wr(fcs_pkg::REG_IRQ_STAT, 32'h1);
    cyc(3);
    cmp(irq, 1'b0, "irq cleared");
    wr(fcs_pkg::REG_IRQ_MASK, 32'h0);
    @(posedge core_clk);
    self_test_button <= 1'b1;
    cyc(20);
    btn_off();
    press(t);
    cmp(32'(t >= 30 && t <= 50), 32'h1, "delay restarts");
    cmp(irq, 1'b0, "masked irq");
    btn_off();
    @(posedge core_clk);
    bypass_switch <= 1'b1;
    cyc(3);
    cmp(32'(disp), 32'h118, "bypass display");
    cmp(fault_indicator, 1'b1, "bypass lamp");
    @(posedge core_clk);
    select_button <= 1'b1;
    cyc(2);
    @(posedge core_clk);
    select_button <= 1'b0;
    cyc(3);
    cmp(32'(disp), 32'h128, "next detector");
    @(posedge core_clk);
    bypass_switch <= 1'b0;
    cyc(3);
    cmp(fault_indicator, 1'b0, "bypass off");
    @(posedge core_clk);
    present_mask <= 8'hfb;
    cyc(3);
    cmp(32'(disp), 32'h132, "missing detector");
    cmp({fault_relay, fault_indicator}, 2'b01, "fault outputs");
    wr(fcs_pkg::REG_CTRL, 32'h48);
    cyc(40);
    cmp({fault_relay, 23'(disp)}, 24'h800000, "short scan ok");
    wr(fcs_pkg::REG_CTRL, 32'h64);
    rdchk(fcs_pkg::REG_CTRL, 32'h48, "count 9 refused");
    @(posedge core_clk);
    echo_mask <= 8'hfe;
    cyc(40);
    cmp(fault_relay, 1'b0, "optical fail");
    @(posedge core_clk);
    echo_mask <= 8'hff;
    present_mask <= 8'hff;
    wr(fcs_pkg::REG_CTRL, 32'h160);
    rdchk(fcs_pkg::REG_CTRL, 32'h60, "five loops refused");
    // A full scan of eight heads refreshes the optical fail of head one.
    cyc(90);
    @(posedge core_clk);
    eol_sense <= 3'h2;
    cyc(3);
    cmp(32'(disp), 32'h103, "wire fault");
    wr(fcs_pkg::REG_CTRL, 32'ha0);
    cyc(3);
    cmp(fault_relay, 1'b1, "two loops match");
    wr(fcs_pkg::REG_CTRL, 32'h60);
    eol_sense <= 3'h1;
    remote_reset_closed <= 1'b0;
    present_mask <= 8'hfb;
    cyc(3);
    @(posedge core_clk);
    present_mask <= 8'hff;
    // A full scan clears any optical fail that the floating echo left behind.
    cyc(90);
    cmp({fault_relay, fault_indicator}, 2'b11, "fault latched");
    @(posedge core_clk);
    remote_reset_closed <= 1'b1;
    cyc(3);
    cmp(fault_indicator, 1'b0, "reset closure");
    report_and_stop();
  end
endmodule
